// File: core/burner_pkg.sv
// Purpose: Shared constants, types and register map of the burner safety sequencer.
// Assumes: 10 MHz core clock and a 100 ms sequence tick.
// Notes:   Sequence times are held in milliseconds and converted to ticks here.
package burner_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [7:0] ticks_t;
  localparam ticks_t TICK_ONE  = 8'h01;
  localparam ticks_t TICKS_MAX = 8'hFF;

  // Least times round up to whole ticks, longest times round down.
  localparam int unsigned TEST_MIN_MS    = 500;
  localparam int unsigned TEST_MAX_MS    = 2000;
  localparam int unsigned EXT_SHORT_MS   = 5000;
  localparam int unsigned EXT_LONG_MS    = 15000;
  localparam int unsigned SA_SHORT_MS    = 3000;
  localparam int unsigned SA_MID_MS      = 5000;
  localparam int unsigned SA_LONG_MS     = 10000;
  localparam int unsigned TZ_SHORT_MS    = 2000;
  localparam int unsigned TZ_MID_MS      = 3000;
  localparam int unsigned TZ_LONG_MS     = 7000;
  localparam int unsigned SB_SHORT_MS    = 1000;
  localparam int unsigned SB_LONG_MS     = 2000;
  localparam int unsigned RECYCLE_WIN_MS = 3000;
  localparam int unsigned POST_MS        = 15000;

  localparam ticks_t TEST_MIN_T  = ticks_t'((TEST_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t TEST_MAX_T  = ticks_t'(TEST_MAX_MS / TICK_MS);
  localparam ticks_t EXT_SHORT_T = ticks_t'(EXT_SHORT_MS / TICK_MS);
  localparam ticks_t EXT_LONG_T  = ticks_t'(EXT_LONG_MS / TICK_MS);
  localparam ticks_t SA_SHORT_T  = ticks_t'(SA_SHORT_MS / TICK_MS);
  localparam ticks_t SA_MID_T    = ticks_t'(SA_MID_MS / TICK_MS);
  localparam ticks_t SA_LONG_T   = ticks_t'(SA_LONG_MS / TICK_MS);
  localparam ticks_t TZ_SHORT_T  = ticks_t'(TZ_SHORT_MS / TICK_MS);
  localparam ticks_t TZ_MID_T    = ticks_t'(TZ_MID_MS / TICK_MS);
  localparam ticks_t TZ_LONG_T   = ticks_t'(TZ_LONG_MS / TICK_MS);
  // One tick is given up so that tick phase never stretches the response.
  localparam ticks_t SB_SHORT_T  = ticks_t'(SB_SHORT_MS / TICK_MS - 1);
  localparam ticks_t SB_LONG_T   = ticks_t'(SB_LONG_MS / TICK_MS - 1);
  localparam ticks_t RECYCLE_T   = ticks_t'((RECYCLE_WIN_MS + TICK_MS - 1) / TICK_MS);
  localparam ticks_t POST_T      = ticks_t'(POST_MS / TICK_MS);

  localparam logic [1:0] SEL_MID  = 2'h1;
  localparam logic [1:0] SEL_LONG = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TEST, ST_TRIAL, ST_RUN, ST_SHUT, ST_LOCK
  } state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_FALSE_FLAME, CAUSE_NO_IGNITION, CAUSE_FLAME_LOSS,
    CAUSE_POST_FLAME, CAUSE_AC_FLAME
  } cause_t;

  typedef struct packed {
    logic       heat;
    logic       flame_dc;
    logic       flame_ac;
    logic       reset_local;
    logic       reset_remote;
  } pins_t;

  typedef struct packed {
    logic       recycle_en;
    logic       sb_v1_long;
    logic       sb_v2_long;
    logic [1:0] safety_sel;
    logic       ext_long;
    logic [4:0] test_ticks;
  } cfg_t;

  localparam int   CFG_W     = $bits(cfg_t);
  localparam cfg_t CFG_RESET = 11'h014;

  typedef struct packed {
    logic [22:0] rsvd;
    logic        recycled;
    logic        heat;
    logic        flame;
    cause_t      cause;
    state_t      state;
  } status_t;

  localparam int IRQ_W       = 5;
  localparam int IRQ_LOCK    = 0;
  localparam int IRQ_START   = 1;
  localparam int IRQ_V2      = 2;
  localparam int IRQ_LOSS    = 3;
  localparam int IRQ_RECYCLE = 4;

  localparam logic [ADDR_W-1:0] ADDR_CFG     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'h10;

endpackage : burner_pkg

// File: core/burner_safety_sequencer.sv
// Purpose: Gas burner safety sequencer with flame supervision and latched lockout.
// Assumes: Pins are asynchronous levels, active high; 10 MHz core clock.
// Notes:   Config writes act at once; change them only while the burner is idle.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Before start, a configurable testing period checks that no flame is seen.
// - Heat request plus clean test energizes first valve and ignition together.
// - False flame stretches testing up to a 5 or 15 s limit, then lockout.
// - Ignition safety period selectable 3, 5 or 10 s; flame needed within it.
// - Flame present at end of safety period opens the second gas valve.
// - No flame at end of safety period drops outputs and locks out.
// - Ignition stays on 2, 3 or 7 s, paired with the safety period.
// - While running the flame is watched continuously for loss.
// - After shutdown a flame lasting about 15 s causes lockout.
// - Lockout drives both the local and the external fault indication.
// - Only a fresh press of local or remote reset leaves lockout.
// - Standard variant: flame loss while running locks out.
// - Recycle variant: flame loss shuts down and repeats start once.
// - Recycle variant: second loss within the first 3 s of running after recycle locks out.
// - Valves drop within their own 1 or 2 s flame-loss response period.
// - Only a DC flame counts; an alternating flame signal is a fault.
module burner_safety_sequencer #(
  parameter int unsigned TICK_CYCLES_P = burner_pkg::TICK_CYCLES
) (
  input  wire logic                            core_clk_in,
  input  wire logic                            reset_n_in,
  input  wire burner_pkg::pins_t               pins_in,
  input  wire logic [burner_pkg::ADDR_W-1:0]   bus_addr_in,
  input  wire logic [burner_pkg::DATA_W-1:0]   bus_wdata_in,
  input  wire logic                            bus_wr_in,
  input  wire logic                            bus_rd_in,
  output logic      [burner_pkg::DATA_W-1:0]   bus_rdata_out,
  output logic                                 first_gas_valve_out,
  output logic                                 second_gas_valve_out,
  output logic                                 ignition_out,
  output logic                                 fault_led_out,
  output logic                                 fault_ext_out,
  output logic                                 irq_out
);
  import burner_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES_P);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES_P - 1);

  pins_t            pins_s;
  logic [DIV_W-1:0] div_r;
  logic             tick_r;
  state_t           state_r;
  state_t           state_nxt;
  cause_t           cause_r;
  cause_t           cause_nxt;
  ticks_t           tmr_r;
  ticks_t           tmr_nxt;
  ticks_t           aux_r;
  ticks_t           aux_nxt;
  logic             recycled_r;
  logic             rst_prev_r;
  cfg_t             cfg_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr_mask;
  logic [DATA_W-1:0] rd_val;
  status_t          status_w;

  pin_sync #(.WIDTH($bits(pins_t))) u_pin_sync (
    .clk_in     (core_clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (pins_in),
    .q_out      (pins_s)
  );

  // Sequence tick: one-cycle enable every TICK_CYCLES_P core cycles.
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (div_r == DIV_LAST)
    begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + DIV_W'(1);
      tick_r <= 1'b0;
    end
  end

  wire heat      = pins_s.heat;
  wire flame_dc  = pins_s.flame_dc;
  wire flame_ac  = pins_s.flame_ac;
  wire flame_ok  = flame_dc & ~flame_ac;
  wire rst_any   = pins_s.reset_local | pins_s.reset_remote;
  wire rst_req   = rst_any & ~rst_prev_r;

  // Configured periods, all in ticks.
  wire ticks_t test_raw = ticks_t'(cfg_r.test_ticks);
  wire ticks_t test_t   = (test_raw < TEST_MIN_T) ? TEST_MIN_T :
                          (test_raw > TEST_MAX_T) ? TEST_MAX_T : test_raw;
  wire ticks_t ext_t    = cfg_r.ext_long ? EXT_LONG_T : EXT_SHORT_T;
  wire ticks_t sa_t     = (cfg_r.safety_sel == SEL_MID)  ? SA_MID_T :
                          (cfg_r.safety_sel == SEL_LONG) ? SA_LONG_T : SA_SHORT_T;
  wire ticks_t tz_t     = (cfg_r.safety_sel == SEL_MID)  ? TZ_MID_T :
                          (cfg_r.safety_sel == SEL_LONG) ? TZ_LONG_T : TZ_SHORT_T;
  wire ticks_t v1_t     = cfg_r.sb_v1_long ? SB_LONG_T : SB_SHORT_T;
  wire ticks_t v2_t     = cfg_r.sb_v2_long ? SB_LONG_T : SB_SHORT_T;

  wire test_pass = heat & ~flame_dc & (aux_r >= test_t);
  wire trial_end = tmr_r >= sa_t;
  wire loss_act  = (state_r == ST_RUN) & (aux_r >= v1_t);
  wire rec_go    = loss_act & cfg_r.recycle_en & ~recycled_r;

  always_comb
  begin
    state_nxt = state_r;
    cause_nxt = CAUSE_NONE;
    case (state_r)
      ST_IDLE:
        if (heat)
          state_nxt = ST_TEST;
      ST_TEST:
        if (test_pass)
          state_nxt = ST_TRIAL;
        else if (!heat)
          state_nxt = ST_IDLE;
        else if (tmr_r >= ext_t)
        begin
          state_nxt = ST_LOCK;
          cause_nxt = CAUSE_FALSE_FLAME;
        end
      ST_TRIAL:
        if (trial_end && flame_ok)
          state_nxt = ST_RUN;
        else if (trial_end)
        begin
          state_nxt = ST_LOCK;
          cause_nxt = CAUSE_NO_IGNITION;
        end
        else if (!heat)
          state_nxt = ST_SHUT;
      ST_RUN:
        if (rec_go)
          state_nxt = ST_TEST;
        else if (loss_act)
        begin
          state_nxt = ST_LOCK;
          cause_nxt = CAUSE_FLAME_LOSS;
        end
        else if (!heat)
          state_nxt = ST_SHUT;
      ST_SHUT:
        if (!flame_dc)
          state_nxt = ST_IDLE;
        else if (tmr_r >= POST_T)
        begin
          state_nxt = ST_LOCK;
          cause_nxt = CAUSE_POST_FLAME;
        end
      ST_LOCK:
        if (rst_req)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_LOCK;
    endcase
    // An alternating flame signal overrides every other decision outside lockout.
    if (flame_ac && state_r != ST_LOCK)
    begin
      state_nxt = ST_LOCK;
      cause_nxt = CAUSE_AC_FLAME;
    end
  end

  wire chg     = state_nxt != state_r;
  wire tmr_inc = tick_r & (tmr_r != TICKS_MAX);
  wire aux_inc = tick_r & (aux_r != TICKS_MAX);
  // Aux counts quiet ticks in testing and flame-loss ticks while running.
  wire aux_clr = chg | ((state_r == ST_TEST) ? flame_dc :
                        (state_r == ST_RUN)  ? flame_ok : 1'b1);

  assign tmr_nxt = chg ? '0 : (tmr_inc ? tmr_r + TICK_ONE : tmr_r);
  assign aux_nxt = aux_clr ? '0 : (aux_inc ? aux_r + TICK_ONE : aux_r);

  wire enter_lock = (state_nxt == ST_LOCK) & (state_r != ST_LOCK);
  // The recycle grant expires after a steady run of the recycle window.
  wire rec_clear  = (state_r == ST_IDLE) | (state_r == ST_LOCK) |
                    ((state_r == ST_RUN) & (tmr_r >= RECYCLE_T));

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r    <= ST_IDLE;
      cause_r    <= CAUSE_NONE;
      tmr_r      <= '0;
      aux_r      <= '0;
      recycled_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      cause_r    <= enter_lock ? cause_nxt : (state_nxt == ST_IDLE ? CAUSE_NONE : cause_r);
      tmr_r      <= tmr_nxt;
      aux_r      <= aux_nxt;
      recycled_r <= rec_go | (recycled_r & ~rec_clear);
      rst_prev_r <= rst_any;
    end
  end

  wire v1_nxt  = (state_r == ST_TRIAL) | ((state_r == ST_RUN) & (aux_r < v1_t));
  wire v2_nxt  = (state_r == ST_RUN) & (aux_r < v2_t);
  wire ign_nxt = (state_r == ST_TRIAL) & (tmr_r < tz_t);

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      first_gas_valve_out  <= 1'b0;
      second_gas_valve_out <= 1'b0;
      ignition_out         <= 1'b0;
      fault_led_out        <= 1'b0;
      fault_ext_out        <= 1'b0;
    end
    else
    begin
      first_gas_valve_out  <= v1_nxt;
      second_gas_valve_out <= v2_nxt;
      ignition_out         <= ign_nxt;
      fault_led_out        <= state_r == ST_LOCK;
      fault_ext_out        <= state_r == ST_LOCK;
    end
  end

  // Register slave and interrupt status.
  wire wr_cfg = bus_wr_in & (bus_addr_in == ADDR_CFG);
  wire wr_en  = bus_wr_in & (bus_addr_in == ADDR_IRQ_EN);
  wire wr_clr = bus_wr_in & (bus_addr_in == ADDR_IRQ_CLR);

  assign ev[IRQ_LOCK]    = enter_lock;
  assign ev[IRQ_START]   = (state_nxt == ST_TRIAL) & (state_r != ST_TRIAL);
  assign ev[IRQ_V2]      = (state_nxt == ST_RUN) & (state_r != ST_RUN);
  assign ev[IRQ_LOSS]    = loss_act;
  assign ev[IRQ_RECYCLE] = rec_go;
  assign clr_mask        = wr_clr ? bus_wdata_in[IRQ_W-1:0] : '0;

  assign status_w = '{rsvd: '0, recycled: recycled_r, heat: heat, flame: flame_ok,
                      cause: cause_r, state: state_r};

  assign rd_val = (bus_addr_in == ADDR_CFG)    ? {{(DATA_W-CFG_W){1'b0}}, cfg_r} :
                  (bus_addr_in == ADDR_STATUS) ? DATA_W'(status_w) :
                  (bus_addr_in == ADDR_IRQ_ST) ? {{(DATA_W-IRQ_W){1'b0}}, irq_st_r} :
                  (bus_addr_in == ADDR_IRQ_EN) ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_r} :
                  '0;

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg_r         <= CFG_RESET;
      irq_en_r      <= '0;
      irq_st_r      <= '0;
      irq_out       <= 1'b0;
      bus_rdata_out <= '0;
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= cfg_t'(bus_wdata_in[CFG_W-1:0]);
      if (wr_en)
        irq_en_r <= bus_wdata_in[IRQ_W-1:0];
      // A new event wins over a clear in the same cycle.
      irq_st_r      <= (irq_st_r & ~clr_mask) | ev;
      irq_out       <= |(irq_st_r & irq_en_r);
      bus_rdata_out <= bus_rd_in ? rd_val : '0;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_lock_outputs_off: assert property ((state_r == ST_LOCK) |=>
    (!first_gas_valve_out && !second_gas_valve_out && !ignition_out))
    else $error("Outputs energized during lockout.");
  chk_lock_fault_shown: assert property ((state_r == ST_LOCK) |=>
    (fault_led_out && fault_ext_out))
    else $error("Fault indication missing in lockout.");
  chk_start_valve_ign: assert property ($rose(first_gas_valve_out) |-> ignition_out)
    else $error("First valve started without ignition.");
  chk_valve2_flame: assert property ($rose(second_gas_valve_out) |->
    ($past(flame_ok, 2) && $past(state_r, 2) == ST_TRIAL))
    else $error("Second valve opened without flame after trial.");
  chk_trial_no_flame: assert property ((state_r == ST_TRIAL && trial_end && !flame_ok) |=>
    (state_r == ST_LOCK) ##1 !first_gas_valve_out)
    else $error("Missing lockout after failed ignition.");
  chk_ac_fault_lock: assert property ((flame_ac && state_r != ST_LOCK) |=>
    (state_r == ST_LOCK && cause_r == CAUSE_AC_FLAME))
    else $error("Alternating flame not treated as fault.");
  chk_lock_held: assert property ((state_r == ST_LOCK && !rst_req) |=>
    (state_r == ST_LOCK))
    else $error("Lockout left without reset press.");
  chk_ign_window: assert property (ignition_out |->
    (first_gas_valve_out && $past(tmr_r) < tz_t && $past(state_r) == ST_TRIAL))
    else $error("Ignition outside its window.");
  chk_loss_v2_drop: assert property ((state_r == ST_RUN && aux_r >= v2_t) |=>
    !second_gas_valve_out)
    else $error("Second valve held after loss response period.");
  chk_recycle_lock: assert property ((loss_act && recycled_r) |=>
    (state_r == ST_LOCK && cause_r == CAUSE_FLAME_LOSS))
    else $error("Second flame loss did not lock out.");
  chk_std_loss_lock: assert property ((loss_act && !cfg_r.recycle_en) |=>
    (state_r == ST_LOCK))
    else $error("Standard variant did not lock out on loss.");
  chk_start_after_test: assert property ($rose(first_gas_valve_out) |->
    ($past(state_r, 2) == ST_TEST && $past(aux_r, 2) >= test_t))
    else $error("Burner started without a full quiet testing period.");
  chk_false_flame_lock: assert property ((state_r == ST_TEST && heat && flame_dc &&
    tmr_r >= ext_t) |=> (state_r == ST_LOCK))
    else $error("False flame outlasted its limit without lockout.");
  chk_post_flame_lock: assert property ((state_r == ST_SHUT && flame_dc &&
    tmr_r >= POST_T) |=> (state_r == ST_LOCK))
    else $error("Flame after shutdown outlasted its limit without lockout.");
  // An alternating flame rightly sends a recycle to lockout instead, so it is left out here.
  chk_recycle_restart: assert property ((rec_go && !flame_ac) |=>
    (state_r == ST_TEST) ##1 (!first_gas_valve_out && !second_gas_valve_out))
    else $error("Recycle did not shut down and return to testing.");
  chk_irq_level: assert property (##1 (irq_out == $past(|(irq_st_r & irq_en_r))))
    else $error("Interrupt output does not follow enabled status.");

  cov_lockout: cover property ($rose(fault_led_out));
  cov_valve2_open: cover property ($rose(second_gas_valve_out));
  cov_recycle: cover property (rec_go ##[1:1000] (state_r == ST_TRIAL));
  cov_post_lock: cover property (enter_lock && state_r == ST_SHUT);

endmodule : burner_safety_sequencer
`default_nettype wire

// File: core/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Pins are slow levels; no bus coherency across bits is needed.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

// File: testbench/burner_partner.sv
// Purpose: Behavioural flame detector facing the burner safety sequencer.
// Assumes: Outside false-flame mode 3, a flame lights only while the first valve and the ignition are both on.
// Notes:   The bench picks a mode to make the flame fail in a chosen way.
`timescale 1ns/100ps
`default_nettype none
module burner_partner #(
  parameter int LIGHT_DLY = 12
) (
  input  wire logic       clk_in,
  input  wire logic       valve_in,
  input  wire logic       ignition_in,
  input  wire logic [2:0] mode_in,
  output logic            flame_dc_out,
  output logic            flame_ac_out
);
  // Modes: 0 normal, 1 never lights, 2 flame lost, 3 false flame, 4 alternating, 5 lingers.
  int unsigned cnt = 0;
  wire         can_burn = (mode_in == 3'h0) || (mode_in == 3'h5);
  initial
  begin
    flame_dc_out = 1'h0;
    flame_ac_out = 1'h0;
  end
  // A lit flame holds on without the spark, as a real burner does.
  always @(posedge clk_in)
  begin
    cnt <= valve_in ? cnt + 1 : 0;
    if (mode_in == 3'h3)
      flame_dc_out <= 1'h1;
    else if (!can_burn)
      flame_dc_out <= 1'h0;
    else if (valve_in && ignition_in && cnt >= LIGHT_DLY)
      flame_dc_out <= 1'h1;
    else if (!valve_in && mode_in != 3'h5)
      flame_dc_out <= 1'h0;
    flame_ac_out <= (mode_in == 3'h4) ? ~flame_ac_out : 1'h0;
  end
endmodule : burner_partner
`default_nettype wire

// File: testbench/burner_safety_sequencer_tb_top.sv
// Purpose: Self-checking bench for the burner safety sequencer.
// Assumes: The tick is shortened to 10 cycles and every time is reckoned in it.
// Notes:   Windows allow one tick of slack, up to two above the post-flame and false-flame limits, as the tick phase runs free.
`timescale 1ns/100ps
`default_nettype none
module burner_safety_sequencer_tb_top;
  import burner_pkg::*;
  localparam int T = 10;
  logic              clk = 1'h0;
  logic              reset_n = 1'h0;
  logic              heat = 1'h0;
  logic              rl = 1'h0;
  logic              rr = 1'h0;
  logic [2:0]        mode = 3'h0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic              wr = 1'h0;
  logic              rd = 1'h0;
  logic [DATA_W-1:0] rdata;
  logic              v1, v2, ign, led, ext, irq, fdc, fac;
  pins_t             pins;
  int                mismatches = 0;
  int                checks_done = 0;
  int                seed = 32'h7D7E;
  assign pins = {heat, fdc, fac, rl, rr};
  always #50 clk = ~clk;
  burner_safety_sequencer #(.TICK_CYCLES_P(T)) dut_u (
    .core_clk_in(clk), .reset_n_in(reset_n), .pins_in(pins),
    .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd),
    .bus_rdata_out(rdata), .first_gas_valve_out(v1), .second_gas_valve_out(v2),
    .ignition_out(ign), .fault_led_out(led), .fault_ext_out(ext), .irq_out(irq));
  burner_partner part_u (
    .clk_in(clk), .valve_in(v1), .ignition_in(ign), .mode_in(mode),
    .flame_dc_out(fdc), .flame_ac_out(fac));
  task automatic close_out();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : bus_wr
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask : bus_rd
  function automatic logic pick(input int w);
    case (w)
      0: return v1;
      1: return v2;
      2: return ign;
      3: return led;
      default: return irq;
    endcase
  endfunction : pick
  task automatic wait_for(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (pick(w) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_for
  task automatic irq_is(input logic v);
    repeat (3) @(negedge clk);
    chk("irq", irq, v);
  endtask : irq_is
  task automatic check_lock(input cause_t c);
    logic [DATA_W-1:0] d;
    bus_rd(ADDR_STATUS, d);
    chk("lock state", d[2:0], 32'(ST_LOCK));
    chk("lock cause", d[5:3], 32'(c));
    chk("lock outputs", {led, ext, v1, v2, ign}, 32'h18);
  endtask : check_lock
  // The flame source is calmed before the press, so a stale fault cannot relock.
  task automatic unlock(input logic remote);
    int n;
    @(posedge clk);
    heat <= 1'h0;
    mode <= 3'h0;
    repeat (4) @(posedge clk);
    if (remote)
      rr <= 1'h1;
    else
      rl <= 1'h1;
    repeat (4) @(posedge clk);
    rl <= 1'h0;
    rr <= 1'h0;
    wait_for(3, 1'h0, 10, n);
    chk("unlock", n < 10, 1'h1);
  endtask : unlock
  task automatic start(input int tt, input int sa, input int ig, input logic lit);
    int n;
    int m;
    @(posedge clk);
    heat <= 1'h1;
    wait_for(0, 1'h1, (tt + 2) * T, n);
    chk("test period", n >= (tt - 1) * T && n < (tt + 1) * T, 1'h1);
    chk("ignition with valve", ign, 1'h1);
    wait_for(2, 1'h0, (ig + 2) * T, n);
    chk("ignition time", n >= (ig - 1) * T && n <= (ig + 1) * T, 1'h1);
    wait_for(lit ? 1 : 3, 1'h1, (sa + 2) * T, m);
    chk("safety period", n + m >= (sa - 1) * T && n + m <= (sa + 1) * T, 1'h1);
    chk("first valve", v1, lit);
  endtask : start
  initial
  begin
    logic [DATA_W-1:0] d;
    cfg_t              cfg;
    int                tt, sa, ig, lim, n, k;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    bus_rd(ADDR_CFG, d);
    chk("cfg reset", d, 32'(CFG_RESET));
    bus_wr(ADDR_STATUS, 32'hFFFF_FFFF);
    bus_rd(ADDR_STATUS, d);
    chk("status read only", d, 32'h0);
    bus_rd(8'hFC, d);
    chk("unmapped", d, 32'h0);
    for (int s = 0; s < 3; s++)
    begin
      cfg = cfg_t'(11'h000);
      cfg.test_ticks = 5'($unsigned($random(seed)) % 16 + 5);
      cfg.safety_sel = 2'(s);
      cfg.sb_v1_long = 1'($random(seed));
      cfg.sb_v2_long = 1'($random(seed));
      cfg.recycle_en = 1'(s == 2);
      bus_wr(ADDR_CFG, 32'(cfg));
      tt = cfg.test_ticks;
      sa = (s == 0 ? SA_SHORT_MS : s == 1 ? SA_MID_MS : SA_LONG_MS) / TICK_MS;
      ig = (s == 0 ? TZ_SHORT_MS : s == 1 ? TZ_MID_MS : TZ_LONG_MS) / TICK_MS;
      lim = (cfg.sb_v1_long ? SB_LONG_MS : SB_SHORT_MS) / TICK_MS * T + 5;
      start(tt, sa, ig, 1'h1);
      if (s == 1)
      begin
        @(posedge clk);
        mode <= 3'h5;
        heat <= 1'h0;
        wait_for(3, 1'h1, (POST_MS / TICK_MS + 2) * T, n);
        chk("post flame", n >= (POST_MS / TICK_MS - 1) * T && n < (POST_MS / TICK_MS + 2) * T, 1'h1);
        check_lock(CAUSE_POST_FLAME);
        unlock(1'h1);
        continue;
      end
      if (s == 2)
      begin
        @(posedge clk);
        mode <= 3'h2;
        wait_for(0, 1'h0, lim + 8, n);
        chk("recycle without lock", {n < lim, led}, 32'h2);
        @(posedge clk);
        mode <= 3'h0;
        wait_for(0, 1'h1, (tt + 2) * T, n);
        chk("restart", n < (tt + 2) * T, 1'h1);
        wait_for(1, 1'h1, (sa + 2) * T, n);
      end
      if (s == 0)
        bus_wr(ADDR_IRQ_EN, 32'h1 << IRQ_LOCK);
      @(posedge clk);
      mode <= 3'h2;
      wait_for(1, 1'h0, lim + 8, n);
      chk("second valve drop", n <= (cfg.sb_v2_long ? SB_LONG_MS : SB_SHORT_MS) / TICK_MS * T + 5, 1'h1);
      wait_for(3, 1'h1, lim + 8, k);
      chk("flame loss lock", n + k <= lim, 1'h1);
      check_lock(CAUSE_FLAME_LOSS);
      if (s == 0)
      begin
        irq_is(1'h1);
        bus_rd(ADDR_IRQ_ST, d);
        chk("irq events", d, 32'((1 << IRQ_LOCK) | (1 << IRQ_START) |
                                 (1 << IRQ_V2) | (1 << IRQ_LOSS)));
        bus_wr(ADDR_IRQ_EN, 32'h0);
        irq_is(1'h0);
        bus_wr(ADDR_IRQ_CLR, 32'h1 << IRQ_LOCK);
        bus_wr(ADDR_IRQ_EN, 32'h1 << IRQ_LOCK);
        irq_is(1'h0);
        @(posedge clk);
        heat <= 1'h0;
        repeat (3 * T) @(posedge clk);
        heat <= 1'h1;
        repeat (3 * T) @(posedge clk);
        check_lock(CAUSE_FLAME_LOSS);
      end
      unlock(1'h0);
    end
    // Select code 3 must act as the short period, and a count of 1 must clamp to the minimum.
    cfg = cfg_t'(11'h0C1);
    cfg.ext_long = 1'($random(seed));
    bus_wr(ADDR_CFG, 32'(cfg));
    @(posedge clk);
    mode <= 3'h1;
    start(TEST_MIN_MS / TICK_MS, SA_SHORT_MS / TICK_MS, TZ_SHORT_MS / TICK_MS, 1'h0);
    check_lock(CAUSE_NO_IGNITION);
    unlock(1'h1);
    lim = (cfg.ext_long ? EXT_LONG_MS : EXT_SHORT_MS) / TICK_MS;
    @(posedge clk);
    mode <= 3'h3;
    heat <= 1'h1;
    wait_for(3, 1'h1, (lim + 2) * T, n);
    chk("false flame limit", n >= (lim - 1) * T && n < (lim + 2) * T, 1'h1);
    check_lock(CAUSE_FALSE_FLAME);
    unlock(1'h0);
    @(posedge clk);
    mode <= 3'h4;
    wait_for(3, 1'h1, 10, n);
    chk("alternating flame", n < 10, 1'h1);
    check_lock(CAUSE_AC_FLAME);
    unlock(1'h1);
    close_out();
  end
  // The whole sequence needs at most some 8,000 cycles; the margin covers slow answers.
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule : burner_safety_sequencer_tb_top
`default_nettype wire
